// file: core/dram_pwr_pkg.sv
// Constants and types for the bank and power-state controller
package dram_pwr_pkg;
   // Register byte offsets
   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] CAPTURE_OFS = 8'h08;
   localparam logic [12:0] MODE_RESET = 13'h0000;
   // Mode field positions and the precharge-all address bit
   localparam int WR_LSB = 9;
   localparam int WR_MSB = 11;
   localparam int PD_SLOW_BIT = 12;
   localparam int PRE_ALL_BIT = 10;
   // Timing: ps figures and clock
   localparam int CLK_PERIOD_PS = 10000;
   localparam int REFRESH_CYCLE_TIME_PS = 127500;
   localparam int SELFREF_EXIT_NONREAD_TIME_PS = 137500;
   localparam int REFRESH_CYCLES =
      (REFRESH_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SELFREF_EXIT_NONREAD_CYCLES =
      (SELFREF_EXIT_NONREAD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SELFREF_EXIT_READ_CYCLES = 200;
   localparam int FAST_PD_EXIT_READ_DELAY = 2;
   localparam int SLOW_PD_EXIT_READ_DELAY = 6;
   localparam int PD_EXIT_NONREAD_DELAY = 2;
   localparam int CLK_GATE_MIN_PULSE = 3;

   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_LMODE
   } dram_cmd_t;

   typedef enum logic [1:0] {
      PWR_ON, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF
   } pwr_t;

   // Pins from the memory controller
   typedef struct packed {
      logic        clk_gate;
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [2:0]  bank;
      logic [12:0] addr;
      logic        termination_enable;
      logic        burst_end;
      logic        lower_byte_strobe;
      logic        upper_byte_strobe;
      logic [15:0] dq;
   } dram_pins_t;
endpackage

// file: core/dram_pwr_ctrl.sv
// Bank, refresh and power-state control with an AHB-Lite register port
`timescale 1ns/10ps
`default_nettype none
module dram_pwr_ctrl
   import dram_pwr_pkg::*;
(
   // Clock and reset
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   // AHB-Lite slave
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic [31:0]                  hrdata,
   // Device pins
   input  wire dram_pwr_pkg::dram_pins_t pins,
   // Device state
   output logic [7:0]                   bank_open,
   output dram_pwr_pkg::pwr_t           pwr_state,
   output logic                         refresh_busy,
   output logic                         dll_frozen,
   output logic                         input_buffers_on,
   output logic                         read_allowed,
   output logic                         nonread_allowed
);
   import dram_pwr_pkg::*;

   dram_pins_t  pin_meta;
   dram_pins_t  pin_s;
   logic        gate_q;
   logic [12:0] mode_reg;
   logic [15:0] capture;
   logic        lstb_q;
   logic        ustb_q;
   logic [7:0]  ref_cnt;
   logic [7:0]  read_wait;
   logic [7:0]  nonread_wait;
   logic        ap_pend;
   logic        ap_write;
   logic [2:0]  ap_bank;
   logic [3:0]  ap_cnt;
   logic        ap_close;
   dram_cmd_t   cmd;
   logic        nop_like;
   logic        a_valid;
   logic        a_write;
   logic [7:0]  a_addr;

   function automatic dram_cmd_t decode(input dram_pins_t p);
      logic [2:0] c;
      c = {p.ras_n, p.cas_n, p.we_n};
      if (p.cs_n) begin
         return CMD_NOP;
      end
      unique case (c)
         3'h3: return CMD_ACT;
         3'h5: return CMD_READ;
         3'h4: return CMD_WRITE;
         3'h2: return CMD_PRE;
         3'h1: return CMD_REF;
         3'h0: return CMD_LMODE;
         default: return CMD_NOP;
      endcase
   endfunction

   // Pin synchroniser
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta <= '0;
         pin_s    <= '0;
         gate_q   <= 1'b0;
      end else begin
         pin_meta <= pins;
         pin_s    <= pin_meta;
         gate_q   <= pin_s.clk_gate;
      end
   end

   assign cmd      = decode(pin_s);
   assign nop_like = (cmd == CMD_NOP);

   // Byte capture on rising strobes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         capture <= 16'h0000;
         lstb_q  <= 1'b0;
         ustb_q  <= 1'b0;
      end else begin
         lstb_q <= pin_s.lower_byte_strobe;
         ustb_q <= pin_s.upper_byte_strobe;
         if (pin_s.lower_byte_strobe && !lstb_q) begin
            capture[7:0] <= pin_s.dq[7:0];
         end
         if (pin_s.upper_byte_strobe && !ustb_q) begin
            capture[15:8] <= pin_s.dq[15:8];
         end
      end
   end

   // Mode register: load-mode command wins over a bus write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg <= MODE_RESET;
      end else if (gate_q && pin_s.clk_gate && cmd == CMD_LMODE
                   && pin_s.bank == 3'h0) begin
         mode_reg <= pin_s.addr;
      end else if (a_valid && a_write && a_addr == MODE_OFS) begin
         mode_reg <= hwdata[12:0];
      end
   end

   // Auto precharge scheduling
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_pend  <= 1'b0;
         ap_write <= 1'b0;
         ap_bank  <= 3'h0;
         ap_cnt   <= 4'h0;
      end else begin
         if (ap_close) begin
            ap_pend <= 1'b0;
         end else if (ap_pend && ap_cnt != 4'h0) begin
            ap_cnt <= ap_cnt - 4'h1;
         end else if (ap_pend && pin_s.burst_end && ap_write) begin
            // Recovery from burst end, masked data or not
            ap_cnt <= {1'b0, mode_reg[WR_MSB:WR_LSB]} + 4'h1;
         end
         if (gate_q && (cmd == CMD_READ || cmd == CMD_WRITE)
             && pin_s.addr[PRE_ALL_BIT]) begin
            ap_pend  <= 1'b1;
            ap_write <= (cmd == CMD_WRITE);
            ap_bank  <= pin_s.bank;
            ap_cnt   <= 4'h0;
         end
      end
   end

   assign ap_close = ap_pend && ((ap_cnt == 4'h1)
                     || (!ap_write && pin_s.burst_end && ap_cnt == 4'h0));

   // Per-bank open flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank_open <= 8'h00;
      end else begin
         for (int b = 0; b < 8; b++) begin
            if (gate_q && cmd == CMD_ACT && pin_s.bank == 3'(b)) begin
               bank_open[b] <= 1'b1;
            end else if (gate_q && cmd == CMD_PRE
                         && (pin_s.addr[PRE_ALL_BIT]
                             || pin_s.bank == 3'(b))) begin
               bank_open[b] <= 1'b0;
            end else if (ap_close && ap_bank == 3'(b)) begin
               bank_open[b] <= 1'b0;
            end
         end
      end
   end

   // Power state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_state <= PWR_ON;
      end else begin
         unique case (pwr_state)
            PWR_ON: begin
               if (gate_q && !pin_s.clk_gate && cmd == CMD_REF
                   && bank_open == 8'h00) begin
                  pwr_state <= PWR_SELF_REF;
               end else if (gate_q && !pin_s.clk_gate && nop_like) begin
                  pwr_state <= (bank_open == 8'h00) ? PWR_PRE_PD
                               : PWR_ACT_PD;
               end
            end
            PWR_PRE_PD, PWR_ACT_PD: begin
               if (pin_s.clk_gate && nop_like) begin
                  pwr_state <= PWR_ON;
               end
            end
            PWR_SELF_REF: begin
               if (pin_s.clk_gate) begin
                  pwr_state <= PWR_ON;
               end
            end
         endcase
      end
   end

   assign dll_frozen       = (pwr_state == PWR_PRE_PD) ||
                             (pwr_state == PWR_SELF_REF);
   assign input_buffers_on = (pwr_state == PWR_ON);

   // Refresh busy timer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_cnt <= 8'h00;
      end else if (gate_q && pin_s.clk_gate && cmd == CMD_REF) begin
         ref_cnt <= 8'(REFRESH_CYCLES);
      end else if (ref_cnt != 8'h00) begin
         ref_cnt <= ref_cnt - 8'h01;
      end
   end
   assign refresh_busy = (ref_cnt != 8'h00);

   // Exit timers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         read_wait    <= 8'h00;
         nonread_wait <= 8'h00;
      end else if (pwr_state == PWR_SELF_REF && pin_s.clk_gate) begin
         read_wait    <= 8'(SELFREF_EXIT_READ_CYCLES);
         nonread_wait <= 8'(SELFREF_EXIT_NONREAD_CYCLES);
      end else if (pwr_state == PWR_ACT_PD && pin_s.clk_gate
                   && nop_like) begin
         read_wait    <= mode_reg[PD_SLOW_BIT]
                         ? 8'(SLOW_PD_EXIT_READ_DELAY)
                         : 8'(FAST_PD_EXIT_READ_DELAY);
         nonread_wait <= 8'(PD_EXIT_NONREAD_DELAY);
      end else if (pwr_state == PWR_PRE_PD && pin_s.clk_gate
                   && nop_like) begin
         read_wait    <= 8'(PD_EXIT_NONREAD_DELAY);
         nonread_wait <= 8'(PD_EXIT_NONREAD_DELAY);
      end else begin
         if (read_wait != 8'h00) begin
            read_wait <= read_wait - 8'h01;
         end
         if (nonread_wait != 8'h00) begin
            nonread_wait <= nonread_wait - 8'h01;
         end
      end
   end
   assign read_allowed    = (pwr_state == PWR_ON) && (read_wait == 8'h00);
   assign nonread_allowed = (pwr_state == PWR_ON) && (nonread_wait == 8'h00);

   // AHB-Lite slave, zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_valid <= 1'b0;
         a_write <= 1'b0;
         a_addr  <= 8'h00;
         hrdata  <= 32'h0000_0000;
      end else begin
         a_valid <= hsel && htrans[1] && hready;
         a_write <= hwrite;
         a_addr  <= haddr[7:0];
         if (hsel && htrans[1] && hready && !hwrite) begin
            unique case (haddr[7:0])
               MODE_OFS:    hrdata <= {19'h0, mode_reg};
               STATUS_OFS:  hrdata <= {8'h00, ref_cnt, 1'b0,
                               nonread_allowed, read_allowed, dll_frozen,
                               refresh_busy, ap_pend, pwr_state, bank_open};
               CAPTURE_OFS: hrdata <= {16'h0, capture};
               default:     hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_wr_hold;
      ap_pend && ap_cnt > 4'h1 |=> bank_open[ap_bank];
   endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("bank closed during write recovery");

   property p_wr_count;
      ap_pend && ap_write && ap_cnt == 4'h0 && pin_s.burst_end && !ap_close
      && !(gate_q && (cmd == CMD_READ || cmd == CMD_WRITE))
      |=> ap_cnt == {1'b0, $past(mode_reg[WR_MSB:WR_LSB])} + 4'h1;
   endproperty
   a_wr_count: assert property (p_wr_count)
      else $error("write recovery count wrong");

   property p_low_byte;
      pin_s.lower_byte_strobe && !lstb_q
      |=> capture[7:0] == $past(pin_s.dq[7:0]);
   endproperty
   a_low_byte: assert property (p_low_byte)
      else $error("lower byte not captured");

   property p_pre_all;
      gate_q && cmd == CMD_PRE && pin_s.addr[PRE_ALL_BIT]
      |=> bank_open == 8'h00;
   endproperty
   a_pre_all: assert property (p_pre_all)
      else $error("all-bank precharge left a bank open");

   property p_pre_one;
      gate_q && cmd == CMD_PRE |=> !bank_open[$past(pin_s.bank)];
   endproperty
   a_pre_one: assert property (p_pre_one)
      else $error("precharged bank still open");

   property p_refresh;
      gate_q && pin_s.clk_gate && cmd == CMD_REF |=> refresh_busy [*8];
   endproperty
   a_refresh: assert property (p_refresh)
      else $error("refresh ended early");

   property p_sr_exit;
      pwr_state == PWR_SELF_REF && pin_s.clk_gate
      |=> !read_allowed [*8] ##0
          ($past(read_wait, 7) == 8'(SELFREF_EXIT_READ_CYCLES)
           && $past(nonread_wait, 7) == 8'(SELFREF_EXIT_NONREAD_CYCLES));
   endproperty
   a_sr_exit: assert property (p_sr_exit)
      else $error("self-refresh exit timers wrong");

   property p_pd_class;
      pwr_state == PWR_ON && gate_q && !pin_s.clk_gate && nop_like
      |=> pwr_state == ($past(bank_open) == 8'h00 ? PWR_PRE_PD : PWR_ACT_PD);
   endproperty
   a_pd_class: assert property (p_pd_class)
      else $error("power-down class wrong");

   property p_pd_frozen;
      pwr_state == PWR_PRE_PD |-> dll_frozen && !input_buffers_on;
   endproperty
   a_pd_frozen: assert property (p_pd_frozen)
      else $error("buffers on in power-down");

   property p_fast_exit;
      pwr_state == PWR_ACT_PD && pin_s.clk_gate && nop_like
      && !mode_reg[PD_SLOW_BIT] |=> !read_allowed ##2 read_allowed;
   endproperty
   a_fast_exit: assert property (p_fast_exit)
      else $error("fast power-down exit delay wrong");

   property p_sr_idle;
      pwr_state == PWR_ON ##1 pwr_state == PWR_SELF_REF
      |-> $past(bank_open) == 8'h00;
   endproperty
   a_sr_idle: assert property (p_sr_idle)
      else $error("self refresh entered with open bank");

   c_self_ref: cover property (pwr_state == PWR_SELF_REF ##1
                               pwr_state == PWR_ON);
   c_act_pd:   cover property (pwr_state == PWR_ACT_PD);
   c_auto_pre: cover property (ap_close && ap_write);
endmodule
`default_nettype wire

// file: sim/mc_model.sv
// Memory controller model that drives the device pins
`timescale 1ns/10ps
`default_nettype none
module mc_model
   import dram_pwr_pkg::*;
(
   // Clock
   input  wire logic                     hclk,
   // Requests from the bench
   input  wire dram_pwr_pkg::dram_cmd_t  cmd,
   input  wire logic                     gate,
   input  wire logic [2:0]               bank,
   input  wire logic [12:0]              addr,
   input  wire logic                     burst_end,
   input  wire logic [1:0]               strobe,
   input  wire logic [15:0]              dq,
   // Device pins
   output var dram_pwr_pkg::dram_pins_t  pins
);
   function automatic logic [3:0] code(input dram_cmd_t c);
      case (c)
         CMD_ACT:   return 4'h3;
         CMD_READ:  return 4'h5;
         CMD_WRITE: return 4'h4;
         CMD_PRE:   return 4'h2;
         CMD_REF:   return 4'h1;
         CMD_LMODE: return 4'h0;
         default:   return 4'h7;
      endcase
   endfunction

   initial begin
      pins = '0;
      pins.cs_n = 1'b1;
   end

   always @(posedge hclk) begin
      // One cycle per command, NOP in between
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= code(cmd);
      pins.clk_gate <= gate;
      // Released address lines toggle so stale values never match
      pins.bank <= (cmd == CMD_NOP) ? ~pins.bank : bank;
      pins.addr <= (cmd == CMD_NOP) ? ~pins.addr : addr;
      pins.termination_enable <= 1'b0;
      pins.burst_end <= burst_end;
      pins.lower_byte_strobe <= strobe[0];
      pins.upper_byte_strobe <= strobe[1];
      pins.dq <= (|strobe) ? dq : ~pins.dq;
   end
endmodule
`default_nettype wire

// file: sim/test_dram_precharge_refresh_power_states.sv
// Self-checking bench for the bank and power-state controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("unexpected %s expected %0h seen %0h", nm, exp, got); \
      end \
   end
module test_dram_precharge_refresh_power_states;
   import dram_pwr_pkg::*;
   typedef struct packed {
      dram_cmd_t   c;
      logic [2:0]  b;
      logic [12:0] a;
      logic [7:0]  open;
   } row_t;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        gate, burst_end, refresh_busy, dll_frozen;
   logic        input_buffers_on, read_allowed, nonread_allowed;
   logic [1:0]  htrans, strobe;
   logic [2:0]  hsize, bank;
   logic [3:0]  ps;
   logic [4:0]  flags;
   logic [7:0]  bank_open;
   logic [12:0] addr;
   logic [15:0] dq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   dram_cmd_t   cmd;
   pwr_t        pwr_state;
   dram_pins_t  pins;
   int          err_count, comparisons, rd_low, nr_low, busy_cnt, t[2];
   row_t        rows[7];

   assign hready = hreadyout;
   assign ps = {pwr_state, dll_frozen, input_buffers_on};
   assign flags = {refresh_busy, input_buffers_on, read_allowed,
                   nonread_allowed, dll_frozen};
   mc_model u_mc (.hclk, .cmd, .gate, .bank, .addr, .burst_end, .strobe,
      .dq, .pins);
   dram_pwr_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pins,
      .bank_open, .pwr_state, .refresh_busy, .dll_frozen, .input_buffers_on,
      .read_allowed, .nonread_allowed);

   // Exit-wait and refresh-busy cycle counters
   always @(posedge hclk) begin
      if (pwr_state === PWR_ON && read_allowed === 1'b0)
         rd_low <= rd_low + 1;
      if (pwr_state === PWR_ON && nonread_allowed === 1'b0)
         nr_low <= nr_low + 1;
      if (refresh_busy === 1'b1)
         busy_cnt <= busy_cnt + 1;
   end

   task automatic wait_ready();
      do @(posedge hclk); while (hready !== 1'b1);
   endtask

   task automatic bus(input logic wr, input logic [7:0] ofs,
                      input logic [31:0] wd, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, ofs};
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      q = hrdata;
   endtask

   // Gate levels stand six edges, well over the minimum pulse
   task automatic issue(input dram_cmd_t c, input logic g,
                        input logic [2:0] b, input logic [12:0] a);
      cmd <= c;
      gate <= g;
      bank <= b;
      addr <= a;
      @(posedge hclk);
      cmd <= CMD_NOP;
      repeat (5) @(posedge hclk);
   endtask

   task automatic done_test(input string nm);
      $display("test %s done", nm);
   endtask

   task automatic close_out();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   initial begin
      #100us;
      err_count++;
      close_out();
   end

   initial begin
      rows = '{'{CMD_ACT, 3'h1, 13'h0, 8'h02},
               '{CMD_ACT, 3'h3, 13'h0, 8'h0a},
               '{CMD_PRE, 3'h1, 13'h0, 8'h08},
               '{CMD_ACT, 3'h5, 13'h0, 8'h28},
               '{CMD_ACT, 3'h0, 13'h0, 8'h29},
               '{CMD_PRE, 3'h5, 13'h400, 8'h00},
               '{CMD_LMODE, 3'h0, 13'h1000, 8'h00}};
      {hresetn, hsel, hwrite, gate, burst_end} = '0;
      {htrans, strobe, bank, addr, dq, haddr, hwdata} = '0;
      hsize = 3'h2;
      cmd = CMD_NOP;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      `CHK("ready", 1'b1, hreadyout)
      `CHK("reset flags", 5'h0e, flags)
      `CHK("reset banks", 8'h00, bank_open)
      bus(1'b0, MODE_OFS, 32'h0, rd);
      `CHK("mode reset", {19'h0, MODE_RESET}, rd)
      bus(1'b0, 8'h0c, 32'h0, rd);
      `CHK("unmapped read", 32'h0, rd)
      `CHK("response", 1'b0, hresp)
      done_test("reset");
      issue(CMD_NOP, 1'b1, 3'h0, 13'h0);
      foreach (rows[i]) begin
         issue(rows[i].c, 1'b1, rows[i].b, rows[i].a);
         `CHK("bank flags", rows[i].open, bank_open)
      end
      bus(1'b0, MODE_OFS, 32'h0, rd);
      `CHK("mode from pins", 32'h1000, rd)
      done_test("banks");
      dq <= 16'h1234;
      strobe <= 2'h1;
      @(posedge hclk);
      dq <= 16'h5678;
      strobe <= 2'h2;
      @(posedge hclk);
      strobe <= 2'h0;
      repeat (6) @(posedge hclk);
      bus(1'b0, CAPTURE_OFS, 32'h0, rd);
      `CHK("byte capture", 32'h5634, rd)
      busy_cnt = 0;
      issue(CMD_REF, 1'b1, 3'h0, 13'h400);
      repeat (15) @(posedge hclk);
      `CHK("refresh busy cycles", REFRESH_CYCLES, busy_cnt)
      done_test("refresh");
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, MODE_OFS, i ? 32'h200 : 32'ha00, rd);
         issue(CMD_ACT, 1'b1, 3'h4, 13'h0);
         issue(CMD_WRITE, 1'b1, 3'h4, 13'h400);
         `CHK("open before burst end", 1'b1, bank_open[4])
         burst_end <= 1'b1;
         @(posedge hclk);
         burst_end <= 1'b0;
         t[i] = 0;
         while (bank_open[4] === 1'b1 && t[i] < 40) begin
            @(posedge hclk);
            t[i]++;
         end
      end
      `CHK("recovery difference", 4, t[0] - t[1])
      done_test("auto precharge");
      issue(CMD_ACT, 1'b1, 3'h6, 13'h0);
      issue(CMD_REF, 1'b0, 3'h0, 13'h0);
      `CHK("self refresh refused", PWR_ON, pwr_state)
      issue(CMD_NOP, 1'b1, 3'h0, 13'h0);
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, MODE_OFS, i ? 32'h1000 : 32'h0, rd);
         issue(CMD_NOP, 1'b0, 3'h0, 13'h0);
         `CHK("active pd", {PWR_ACT_PD, 2'h0}, ps)
         rd_low = 0;
         nr_low = 0;
         issue(CMD_NOP, 1'b1, 3'h0, 13'h0);
         repeat (8) @(posedge hclk);
         `CHK("pd read wait", i ? SLOW_PD_EXIT_READ_DELAY : FAST_PD_EXIT_READ_DELAY,
            rd_low)
         `CHK("pd nonread wait", PD_EXIT_NONREAD_DELAY, nr_low)
      end
      issue(CMD_PRE, 1'b1, 3'h6, 13'h0);
      issue(CMD_NOP, 1'b0, 3'h0, 13'h0);
      `CHK("precharge pd", {PWR_PRE_PD, 2'h2}, ps)
      issue(CMD_NOP, 1'b1, 3'h0, 13'h0);
      done_test("power down");
      issue(CMD_REF, 1'b0, 3'h0, 13'h0);
      `CHK("self refresh", {PWR_SELF_REF, 2'h2}, ps)
      bus(1'b0, STATUS_OFS, 32'h0, rd);
      `CHK("status", 13'h1300, rd[12:0])
      rd_low = 0;
      nr_low = 0;
      issue(CMD_NOP, 1'b1, 3'h0, 13'h0);
      repeat (200) @(posedge hclk);
      `CHK("sr read wait", SELFREF_EXIT_READ_CYCLES, rd_low)
      `CHK("sr nonread wait", SELFREF_EXIT_NONREAD_CYCLES, nr_low)
      done_test("self refresh");
      issue(CMD_ACT, 1'b1, 3'h2, 13'h0);
      hresetn <= 1'b0;
      gate <= 1'b0;
      repeat (2) @(posedge hclk);
      `CHK("mid-run reset", {8'h0, PWR_ON}, {bank_open, pwr_state})
      hresetn <= 1'b1;
      repeat (2) begin
         @(posedge hclk);
         `CHK("released flags", 5'h0e, flags)
         `CHK("released state", {8'h0, PWR_ON}, {bank_open, pwr_state})
      end
      issue(CMD_NOP, 1'b1, 3'h0, 13'h0);
      issue(CMD_ACT, 1'b1, 3'h2, 13'h0);
      `CHK("bank after reset", 8'h04, bank_open)
      done_test("second reset");
      close_out();
   end
endmodule
`default_nettype wire
